// [verilog/sbwb_pkg.sv]
// Shared constants and carrier types for the byte-masked burst SRAM core.
package sbwb_pkg;
    localparam int ADDR_W = 8;
    localparam int LANES = 2;
    localparam int LANE_W = 9;
    localparam int WORD_W = LANES * LANE_W;
    localparam int ORIGIN_BIT = 0;
    localparam logic [LANES-1:0] SEL_NONE_N = 2'h3;
    localparam logic [WORD_W-1:0] WORD_RESET = 18'h0_0000;

    typedef struct packed {
        logic [WORD_W-1:0] data;
        logic [LANES-1:0] lane_write_select_n;
    } sbwb_beat_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [ADDR_W-1:0] addr;
    } sbwb_req_s;

    typedef enum logic [1:0] {
        SBWB_IDLE = 2'b00,
        SBWB_WR_SECOND = 2'b01,
        SBWB_RD_SECOND = 2'b10
    } sbwb_phase_e;
endpackage

// [verilog/sbwb_lane_merge.sv]
// Merges one write beat into a stored word lane by lane.
`timescale 1ns/1ps
module sbwb_lane_merge #(
    parameter int LANES = 2,
    parameter int LANE_W = 9
) (
    input wire logic [LANES*LANE_W-1:0] i_old,
    input wire logic [LANES*LANE_W-1:0] i_new,
    input wire logic [LANES-1:0] i_sel_n,
    output logic [LANES*LANE_W-1:0] o_merged
);
    // Refuse a lane geometry that has no bits to merge.
    if (LANES < 1 || LANE_W < 1) begin : g_bad_geometry
        $error("sbwb_lane_merge: bad geometry");
    end

    always_comb begin
        for (int l = 0; l < LANES; l++) begin
            // A high select keeps the old lane.
            o_merged[l*LANE_W +: LANE_W] = i_sel_n[l] ?
                i_old[l*LANE_W +: LANE_W] : i_new[l*LANE_W +: LANE_W];
        end
    end
endmodule

// [verilog/sbwb_core.sv]
// Burst-of-two SRAM core with byte lane writes, ordering and forwarding.
`timescale 1ns/1ps
// Function
// - Each lane is stored only when its active-low select is low.
// - Lane selects are sampled on both halves of every write burst.
// - First word taken on the first beat, second word on the next beat.
// - Read right after a write to that address returns the new data.
// - Lowest address bit picks which word of the pair goes first.
module sbwb_core #(
    parameter int ADDR_W = sbwb_pkg::ADDR_W,
    parameter int LANES = sbwb_pkg::LANES,
    parameter int LANE_W = sbwb_pkg::LANE_W
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_req_valid,
    input wire logic i_req_write,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic i_beat,
    input wire logic [LANES*LANE_W-1:0] i_wdata,
    input wire logic [LANES-1:0] i_lane_write_select_n,
    output logic o_busy,
    output logic o_rvalid,
    output logic [LANES*LANE_W-1:0] o_rdata,
    output logic o_forwarded
);
    localparam int WW = LANES * LANE_W;
    localparam int DEPTH = 1 << ADDR_W;

    // The carrier structs and reset constants are sized by the package,
    // so the port widths must match them exactly.
    if (ADDR_W < 2 || LANES < 1 || LANE_W < 1
        || ADDR_W != sbwb_pkg::ADDR_W || LANES != sbwb_pkg::LANES
        || WW != sbwb_pkg::WORD_W) begin : g_bad_params
        $error("sbwb_core: parameters out of range");
    end

    // Word pairs: index is the address with its lowest bit dropped.
    logic [WW-1:0] mem [0:DEPTH/2-1][0:1];

    sbwb_pkg::sbwb_phase_e phase;
    sbwb_pkg::sbwb_req_s cur;
    sbwb_pkg::sbwb_req_s last_wr;
    logic [WW-1:0] wr_first;
    logic [LANES-1:0] sel_first_n;
    logic [WW-1:0] second_word;
    logic second_fwd;
    logic [ADDR_W-2:0] pair;
    logic origin;
    logic [WW-1:0] merged;
    logic [WW-1:0] old_word;
    logic [WW-1:0] new_word;
    logic [LANES-1:0] new_sel_n;
    logic beat_wr;
    logic beat_rd;
    logic same_addr;

    assign beat_wr = i_beat && phase == sbwb_pkg::SBWB_WR_SECOND;
    assign beat_rd = i_req_valid && !i_req_write && !i_beat
        && phase == sbwb_pkg::SBWB_IDLE;
    assign pair = beat_wr ? cur.addr[ADDR_W-1:1] : i_addr[ADDR_W-1:1];
    assign origin = beat_wr ? cur.addr[0] : i_addr[0];
    assign same_addr = last_wr.valid && last_wr.addr == i_addr;

    // Two beats write words origin and then its partner.
    always_comb begin
        old_word = mem[cur.addr[ADDR_W-1:1]][cur.addr[0]];
        new_word = wr_first;
        new_sel_n = sel_first_n;
    end

    sbwb_lane_merge #(.LANES(LANES), .LANE_W(LANE_W)) u_merge (
        .i_old(old_word),
        .i_new(new_word),
        .i_sel_n(new_sel_n),
        .o_merged(merged)
    );

    logic [WW-1:0] merged2;
    sbwb_lane_merge #(.LANES(LANES), .LANE_W(LANE_W)) u_merge2 (
        .i_old(mem[cur.addr[ADDR_W-1:1]][~cur.addr[0]]),
        .i_new(i_wdata),
        .i_sel_n(i_lane_write_select_n),
        .o_merged(merged2)
    );

    // Request phase tracking; a write holds its slot even if fully masked.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            phase <= sbwb_pkg::SBWB_IDLE;
            cur <= '0;
        end else begin
            case (phase)
                sbwb_pkg::SBWB_IDLE: begin
                    if (i_req_valid && !i_beat) begin
                        cur <= '{valid: 1'b1, write: i_req_write,
                                 addr: i_addr};
                        phase <= i_req_write ? sbwb_pkg::SBWB_WR_SECOND
                                             : sbwb_pkg::SBWB_RD_SECOND;
                    end
                end
                sbwb_pkg::SBWB_WR_SECOND,
                sbwb_pkg::SBWB_RD_SECOND: begin
                    if (i_beat) begin
                        phase <= sbwb_pkg::SBWB_IDLE;
                        cur.valid <= 1'b0;
                    end
                end
                default: phase <= sbwb_pkg::SBWB_IDLE;
            endcase
        end
    end

    // First beat: word and selects captured together.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            wr_first <= sbwb_pkg::WORD_RESET;
            sel_first_n <= sbwb_pkg::SEL_NONE_N;
        end else if (i_req_valid && i_req_write && !i_beat
                     && phase == sbwb_pkg::SBWB_IDLE) begin
            wr_first <= i_wdata;
            sel_first_n <= i_lane_write_select_n;
        end
    end

    // Second beat commits both words with their own lane selects.
    // A burst cut by reset is dropped rather than half stored.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst && beat_wr) begin
            mem[cur.addr[ADDR_W-1:1]][cur.addr[0]] <= merged;
            mem[cur.addr[ADDR_W-1:1]][~cur.addr[0]] <= merged2;
        end
    end

    // Address of the most recent write, for forwarding.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            last_wr <= '0;
        end else if (beat_wr) begin
            last_wr <= cur;
        end else if (phase == sbwb_pkg::SBWB_RD_SECOND && i_beat) begin
            last_wr.valid <= 1'b0;
        end else if (beat_rd) begin
            last_wr.valid <= 1'b0;
        end
    end

    // Read path: the origin word first, the partner on the second beat.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_rvalid <= 1'b0;
            o_rdata <= sbwb_pkg::WORD_RESET;
            o_forwarded <= 1'b0;
            second_word <= sbwb_pkg::WORD_RESET;
            second_fwd <= 1'b0;
        end else if (beat_rd) begin
            o_rvalid <= 1'b1;
            o_forwarded <= same_addr;
            // Memory already holds the finished write; flag marks bypass.
            o_rdata <= mem[pair][origin];
            second_word <= mem[pair][~origin];
            second_fwd <= same_addr;
        end else if (phase == sbwb_pkg::SBWB_RD_SECOND && i_beat) begin
            o_rvalid <= 1'b1;
            o_rdata <= second_word;
            o_forwarded <= second_fwd;
        end else begin
            o_rvalid <= 1'b0;
            o_forwarded <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_busy <= 1'b0;
        end else begin
            o_busy <= (phase == sbwb_pkg::SBWB_IDLE) ? i_req_valid && !i_beat
                                                     : !i_beat;
        end
    end

    sequence s_wr_first;
        i_req_valid && i_req_write && !i_beat
            && phase == sbwb_pkg::SBWB_IDLE;
    endsequence

    sequence s_rd_burst;
        beat_rd ##1 i_beat;
    endsequence

    AST_FIRST_BEAT_HOLDS: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        s_wr_first
        |=> wr_first == $past(i_wdata)
            && sel_first_n == $past(i_lane_write_select_n))
        else $error("first beat not captured");

    AST_WRITE_ENTERS_SECOND: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        s_wr_first
        |=> phase == sbwb_pkg::SBWB_WR_SECOND)
        else $error("write did not wait for second beat");

    AST_MASKED_PARTNER_KEPT: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        beat_wr && &sel_first_n && &i_lane_write_select_n
        |-> merged2 == mem[cur.addr[ADDR_W-1:1]][~cur.addr[0]])
        else $error("masked write changed the partner word");

    AST_READ_PARTNER: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        s_rd_burst
        |=> o_rvalid
            && o_rdata == $past(mem[cur.addr[ADDR_W-1:1]][~cur.addr[0]]))
        else $error("partner word not sent second");

    AST_MASKED_LANE_KEPT: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        beat_wr && &sel_first_n |-> merged == old_word)
        else $error("masked write changed a lane");

    AST_LANE_TAKEN: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        beat_wr && !sel_first_n[0]
        |-> merged[LANE_W-1:0] == wr_first[LANE_W-1:0])
        else $error("selected lane not stored");

    AST_READ_ORDER: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        beat_rd |=> o_rvalid && o_rdata == $past(mem[pair][origin]))
        else $error("burst order wrong");

    AST_FORWARD_FLAG: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        beat_rd && same_addr |=> o_forwarded)
        else $error("forwarding missed");
endmodule

// [testbench/sbwb_ctrl_model.sv]
// Controller model that drives write and read bursts into the SRAM core.
`timescale 1ns/1ps
module sbwb_ctrl_model (
    input wire logic i_sys_clk,
    input wire logic i_rvalid,
    input wire logic [sbwb_pkg::WORD_W-1:0] i_rdata,
    input wire logic i_forwarded,
    output logic o_req_valid,
    output logic o_req_write,
    output logic [sbwb_pkg::ADDR_W-1:0] o_addr,
    output logic o_beat,
    output logic [sbwb_pkg::WORD_W-1:0] o_wdata,
    output logic [sbwb_pkg::LANES-1:0] o_sel_n
);
    localparam int AW = sbwb_pkg::ADDR_W;
    localparam int WW = sbwb_pkg::WORD_W;
    localparam int LN = sbwb_pkg::LANES;
    initial begin
        o_req_valid = 1'b0;
        o_req_write = 1'b0;
        o_addr = 8'h00;
        o_beat = 1'b0;
        o_wdata = 18'h0_0000;
        o_sel_n = 2'h3;
    end
    task automatic wr(input logic [AW-1:0] a, input logic [WW-1:0] w0,
        input logic [LN-1:0] s0, input logic [WW-1:0] w1,
        input logic [LN-1:0] s1);
        @(posedge i_sys_clk);
        o_req_valid <= 1'b1;
        o_req_write <= 1'b1;
        o_addr <= a;
        o_beat <= 1'b0;
        o_wdata <= w0;
        o_sel_n <= s0;
        @(posedge i_sys_clk);
        o_req_valid <= 1'b0;
        o_beat <= 1'b1;
        o_wdata <= w1;
        o_sel_n <= s1;
    endtask
    // Address, data and selects show the inverse of their last value; o_req_write holds.
    task automatic idle();
        @(posedge i_sys_clk);
        o_req_valid <= 1'b0;
        o_beat <= 1'b0;
        o_addr <= ~o_addr;
        o_wdata <= ~o_wdata;
        o_sel_n <= ~o_sel_n;
    endtask
    task automatic rd(input logic [AW-1:0] a, output logic [WW-1:0] w0,
        output logic [WW-1:0] w1, output logic f0, f1, v0, v1);
        @(posedge i_sys_clk);
        o_req_valid <= 1'b1;
        o_req_write <= 1'b0;
        o_addr <= a;
        o_beat <= 1'b0;
        o_wdata <= ~o_wdata;
        @(posedge i_sys_clk);
        o_req_valid <= 1'b0;
        o_beat <= 1'b1;
        @(negedge i_sys_clk);
        w0 = i_rdata;
        f0 = i_forwarded;
        v0 = i_rvalid;
        idle();
        @(negedge i_sys_clk);
        w1 = i_rdata;
        f1 = i_forwarded;
        v1 = i_rvalid;
    endtask
endmodule

// [testbench/sbwb_core_tb.sv]
// Self-checking bench for the byte-masked burst SRAM core.
`timescale 1ns/1ps
module sbwb_core_tb;
    localparam int WW = sbwb_pkg::WORD_W;
    localparam logic [WW-1:0] WA = 18'h1_2345;
    localparam logic [WW-1:0] WB = 18'h2_abcd;
    localparam logic [WW-1:0] WC = 18'h0_0155;
    localparam logic [WW-1:0] WD = 18'h3_fe00;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic req_valid, req_write, beat, busy, rvalid, forwarded, f0, f1;
    logic v0, v1;
    logic [sbwb_pkg::ADDR_W-1:0] addr;
    logic [WW-1:0] wdata, rdata, w0, w1;
    logic [sbwb_pkg::LANES-1:0] sel_n;
    int n_errors = 0;
    int compares = 0;
    initial begin
        forever #10 i_sys_clk = ~i_sys_clk;
    end
    sbwb_core u_sbwb_core (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_req_valid(req_valid), .i_req_write(req_write), .i_addr(addr),
        .i_beat(beat), .i_wdata(wdata), .i_lane_write_select_n(sel_n),
        .o_busy(busy), .o_rvalid(rvalid), .o_rdata(rdata),
        .o_forwarded(forwarded));
    sbwb_ctrl_model u_sbwb_ctrl_model (.i_sys_clk(i_sys_clk),
        .i_rvalid(rvalid), .i_rdata(rdata), .i_forwarded(forwarded),
        .o_req_valid(req_valid), .o_req_write(req_write), .o_addr(addr),
        .o_beat(beat), .o_wdata(wdata), .o_sel_n(sel_n));
    task automatic chk_word(input logic [WW-1:0] got, exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [WW-1:0] e0, e1);
        u_sbwb_ctrl_model.rd(a, w0, w1, f0, f1, v0, v1);
        chk_bit(v0, 1'b1);
        chk_bit(v1, 1'b1);
        chk_word(w0, e0);
        chk_word(w1, e1);
    endtask
    task automatic t_reset();
        @(negedge i_sys_clk);
        chk_bit(rvalid, 1'b0);
        chk_bit(busy, 1'b0);
        $display("test reset done");
    endtask
    task automatic t_lanes();
        u_sbwb_ctrl_model.wr(8'h10, WA, 2'h0, WB, 2'h0);
        @(negedge i_sys_clk);
        chk_bit(busy, 1'b1);
        u_sbwb_ctrl_model.wr(8'h10, WC, 2'h2, WD, 2'h1);
        rd_chk(8'h10, {WA[17:9], WC[8:0]}, {WD[17:9], WB[8:0]});
        chk_bit(f0, 1'b1);
        chk_bit(f1, 1'b1);
        $display("test lanes done");
    endtask
    task automatic t_order();
        u_sbwb_ctrl_model.wr(8'h21, WC, 2'h0, WD, 2'h0);
        u_sbwb_ctrl_model.idle();
        rd_chk(8'h20, WD, WC);
        rd_chk(8'h21, WC, WD);
        $display("test order done");
    endtask
    task automatic t_mask();
        u_sbwb_ctrl_model.wr(8'h21, ~WA, 2'h3, ~WB, 2'h3);
        rd_chk(8'h21, WC, WD);
        chk_bit(f0, 1'b1);
        $display("test mask done");
    endtask
    // Reset lands on the second beat: the burst must leave no trace.
    task automatic t_rst_mid();
        u_sbwb_ctrl_model.wr(8'h21, ~WA, 2'h0, ~WB, 2'h0);
        i_rst <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        @(negedge i_sys_clk);
        chk_bit(busy, 1'b0);
        chk_bit(rvalid, 1'b0);
        rd_chk(8'h21, WC, WD);
        chk_bit(f0, 1'b0);
        $display("test mid-run reset done");
    endtask
    initial begin
        repeat (2000) @(posedge i_sys_clk);
        n_errors++;
        $display("MISMATCH %0t run did not finish", $time);
        end_sim();
    end
    initial begin
        repeat (10) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        t_reset();
        t_lanes();
        t_order();
        t_mask();
        t_rst_mid();
        end_sim();
    end
endmodule
